// File: zam_regs.svh
// Timing constants and reset values for the zone accumulation motor controller.
`ifndef ZAM_REGS_SVH
`define ZAM_REGS_SVH
`define ZAM_CLK_HZ        200000000
`define ZAM_TICK_HZ       1000
`define ZAM_TICK_CYCLES   (`ZAM_CLK_HZ / `ZAM_TICK_HZ)
`define ZAM_ATTEMPTS_RST  8'h00
`define ZAM_ZERO8         8'h00
`define ZAM_ZERO16        16'h0000
`define ZAM_ONE16         16'h0001
`define ZAM_ONE8          8'h01
`define ZAM_MS_MAX        16'hFFFF
`endif

// File: zam_pkg.sv
// Types for the zone accumulation motor controller.
package zam_pkg;
  typedef enum logic [1:0] {
    ZAM_CH_RUN,
    ZAM_CH_WAIT,
    ZAM_CH_LATCHED
  } zam_ch_state_t;
  typedef enum logic [1:0] {
    ZAM_Z_EMPTY,
    ZAM_Z_ARRIVING,
    ZAM_Z_HOLD,
    ZAM_Z_RELEASE
  } zam_zone_state_t;
endpackage

// File: zam_channel.sv
// One motor channel: commutation error recovery and PI velocity loop with feed-forward.
`timescale 1ns/1ps
`include "zam_regs.svh"
module zam_channel
  import zam_pkg::*;
#(
  parameter int VW = 16
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ms_tick,
  input  wire logic          commut_err,
  input  wire logic          manual_ack,
  input  wire logic [7:0]    max_attempts,
  input  wire logic [15:0]   ack_delay_ms,
  input  wire logic          run_req,
  input  wire logic signed [VW-1:0] vel_set,
  input  wire logic signed [VW-1:0] vel_meas,
  input  wire logic [7:0]    kp,
  input  wire logic [7:0]    ti,
  input  wire logic [7:0]    kff,
  output logic               enabled_r,
  output logic               latched_r,
  output logic [7:0]         attempts_r,
  output logic [15:0]        since_ack_ms_r,
  output logic signed [VW-1:0] drive_r
);
  zam_ch_state_t      st_r;
  logic [15:0]        wait_ms_r;
  logic signed [VW+15:0] integ_r;
  logic [7:0]         ti_cnt_r;
  logic signed [VW:0] err;
  logic signed [VW+15:0] ff_term;
  logic signed [VW+15:0] p_term;
  logic signed [VW+15:0] sum;
  logic               auto_ok;

  // Same path whether commanded centrally or by zone logic.
  assign auto_ok = (max_attempts != `ZAM_ATTEMPTS_RST) && (attempts_r < max_attempts);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r       <= ZAM_CH_RUN;
      wait_ms_r  <= `ZAM_ZERO16;
      attempts_r <= `ZAM_ZERO8;
    end else begin
      case (st_r)
        ZAM_CH_RUN: begin
          if (commut_err) begin
            wait_ms_r <= `ZAM_ZERO16;
            st_r      <= auto_ok ? ZAM_CH_WAIT : ZAM_CH_LATCHED;
          end
        end
        ZAM_CH_WAIT: begin
          if (manual_ack) begin
            st_r       <= ZAM_CH_RUN;
            attempts_r <= `ZAM_ZERO8;
          end else if (wait_ms_r >= ack_delay_ms) begin
            st_r       <= ZAM_CH_RUN;
            attempts_r <= attempts_r + `ZAM_ONE8;
          end else if (ms_tick) begin
            wait_ms_r <= wait_ms_r + `ZAM_ONE16;
          end
        end
        ZAM_CH_LATCHED: begin
          if (manual_ack) begin
            st_r       <= ZAM_CH_RUN;
            attempts_r <= `ZAM_ZERO8;
          end
        end
        default: st_r <= ZAM_CH_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enabled_r <= 1'b0;
      latched_r <= 1'b0;
    end else begin
      enabled_r <= (st_r == ZAM_CH_RUN) && !commut_err;
      latched_r <= (st_r == ZAM_CH_LATCHED);
    end
  end

  // Elapsed time since the last automatic acknowledgement; saturates rather than wraps.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_ack_ms_r <= `ZAM_ZERO16;
    end else if (st_r == ZAM_CH_WAIT && !manual_ack && wait_ms_r >= ack_delay_ms) begin
      since_ack_ms_r <= `ZAM_ZERO16;
    end else if (ms_tick && since_ack_ms_r != `ZAM_MS_MAX) begin
      since_ack_ms_r <= since_ack_ms_r + `ZAM_ONE16;
    end
  end

  assign err     = (VW+1)'(vel_set) - (VW+1)'(vel_meas);
  assign ff_term = (VW+16)'(vel_set) * $signed({1'b0, kff});
  assign p_term  = (VW+16)'(err) * $signed({1'b0, kp});
  // Gain zero leaves pure feed-forward; the integrator is held cleared to zero to avoid windup.
  assign sum     = (kp == `ZAM_ZERO8) ? ff_term : (ff_term + p_term + integ_r);

  // Integral time is applied as a divider on the integration rate, updated per ms.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      integ_r  <= '0;
      ti_cnt_r <= `ZAM_ZERO8;
    end else if (!enabled_r || !run_req || kp == `ZAM_ZERO8) begin
      integ_r  <= '0;
      ti_cnt_r <= `ZAM_ZERO8;
    end else if (ms_tick) begin
      if (ti_cnt_r >= ti) begin
        ti_cnt_r <= `ZAM_ZERO8;
        integ_r  <= integ_r + p_term;
      end else begin
        ti_cnt_r <= ti_cnt_r + `ZAM_ONE8;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_r <= '0;
    end else if (!enabled_r || !run_req) begin
      drive_r <= '0;
    end else begin
      drive_r <= sum[VW+7:8];
    end
  end
endmodule // zam_channel

// File: zam_top.sv
// Two-channel zone accumulation motor controller top level.
// Functional notes
// - A commutation error disables the affected channel.
// - Auto acknowledge waits the set milliseconds, then re-enables and restarts.
// - Beyond the attempt limit, latch an error cleared only by manual acknowledge.
// - Attempt limit zero disables auto acknowledge; zero is the reset default.
// - Count auto acknowledged errors; clear on power-up and on manual acknowledge while waiting or latched.
// - Provide milliseconds elapsed since the last auto acknowledge.
// - Auto acknowledge acts the same in central and zone mode.
// - Forward a package only when the next zone is free.
// - On package arrival stop the motor and wait for downstream free.
// - When the zone empties, tell upstream the zone is free.
// - After free, tell downstream a package comes; both motors run.
// - Singulated release reports free once the package leaves the sensor.
// - Train release reports free as soon as onward conveying starts.
// - Two zones handshake internally with no external wiring.
// - Outer handshake selectable: discrete pins or fieldbus values.
// - PI velocity loop plus feed-forward with configurable gains.
// - Proportional gain zero leaves only scaled feed-forward.
// - Sensor high means package present unless low-active is selected.
`timescale 1ns/1ps
`include "zam_regs.svh"
module zam_top
  import zam_pkg::*;
#(
  parameter int VW         = 16,
  parameter int TICK_CYCLES = `ZAM_TICK_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [1:0]        sensor_pin,
  input  wire logic [1:0]        sensor_low_active,
  input  wire logic [1:0]        commut_err,
  input  wire logic [1:0]        manual_ack,
  input  wire logic [7:0]        max_attempts,
  input  wire logic [15:0]       ack_delay_ms,
  input  wire logic              zone_mode,
  input  wire logic [1:0]        central_run,
  input  wire logic              train_release,
  input  wire logic              link_via_bus,
  input  wire logic              up_coming_pin,
  input  wire logic              dn_free_pin,
  input  wire logic              up_coming_bus,
  input  wire logic              dn_free_bus,
  input  wire logic signed [VW-1:0] vel_set0,
  input  wire logic signed [VW-1:0] vel_set1,
  input  wire logic signed [VW-1:0] vel_meas0,
  input  wire logic signed [VW-1:0] vel_meas1,
  input  wire logic [7:0]        kp,
  input  wire logic [7:0]        ti,
  input  wire logic [7:0]        kff,
  output logic                   up_free_pin_r,
  output logic                   dn_coming_pin_r,
  output logic                   up_free_bus_r,
  output logic                   dn_coming_bus_r,
  output logic [1:0]             ch_enabled_r,
  output logic [1:0]             ch_latched_r,
  output logic [7:0]             attempts0_r,
  output logic [7:0]             attempts1_r,
  output logic [15:0]            since_ack0_r,
  output logic [15:0]            since_ack1_r,
  output logic signed [VW-1:0]   drive0_r,
  output logic signed [VW-1:0]   drive1_r,
  output logic [1:0]             zone_full_r
);
  logic        rs1_r, rst_n;
  logic [31:0] pre_r;
  logic        ms_tick_r;
  logic [3:0]  sync1_r, sync2_r;
  logic [1:0]  present;
  logic        up_coming_in, dn_free_in;
  zam_zone_state_t zst_r [2];
  logic [1:0]  zfree_r, zcoming_r, zrun;
  logic [1:0]  zone_free_in, zone_coming_in;
  logic [1:0]  run_req;
  logic [1:0]  en_w, lat_w;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r     <= '0;
      ms_tick_r <= 1'b0;
    end else if (pre_r == 32'(TICK_CYCLES - 1)) begin
      pre_r     <= '0;
      ms_tick_r <= 1'b1;
    end else begin
      pre_r     <= pre_r + 32'h00000001;
      ms_tick_r <= 1'b0;
    end
  end

  // Pins from outside pass two flops; the first stage feeds nothing else.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= {dn_free_pin, up_coming_pin, sensor_pin};
      sync2_r <= sync1_r;
    end
  end

  assign present      = sync2_r[1:0] ^ sensor_low_active;
  assign up_coming_in = link_via_bus ? up_coming_bus : sync2_r[2];
  assign dn_free_in   = link_via_bus ? dn_free_bus : sync2_r[3];
  // Zone 0 is upstream of zone 1; they talk through internal signals.
  assign zone_free_in   = {dn_free_in, zfree_r[1]};
  assign zone_coming_in = {zcoming_r[0], up_coming_in};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_zone
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          zst_r[g]     <= ZAM_Z_EMPTY;
          zfree_r[g]   <= 1'b0;
          zcoming_r[g] <= 1'b0;
        end else begin
          case (zst_r[g])
            ZAM_Z_EMPTY: begin
              zcoming_r[g] <= 1'b0;
              zfree_r[g]   <= 1'b1;
              if (present[g]) begin
                zst_r[g] <= ZAM_Z_HOLD;
              end else if (zone_coming_in[g]) begin
                zst_r[g] <= ZAM_Z_ARRIVING;
              end
            end
            ZAM_Z_ARRIVING: begin
              if (present[g]) begin
                zfree_r[g] <= 1'b0;
                zst_r[g]   <= ZAM_Z_HOLD;
              end
            end
            ZAM_Z_HOLD: begin
              zfree_r[g] <= 1'b0;
              if (!present[g]) begin
                zst_r[g] <= ZAM_Z_EMPTY;
              end else if (zone_free_in[g]) begin
                zcoming_r[g] <= 1'b1;
                zst_r[g]     <= ZAM_Z_RELEASE;
              end
            end
            ZAM_Z_RELEASE: begin
              zfree_r[g] <= train_release;
              if (!present[g]) begin
                zst_r[g] <= ZAM_Z_EMPTY;
              end
            end
            default: zst_r[g] <= ZAM_Z_EMPTY;
          endcase
        end
      end

      assign zrun[g]    = (zst_r[g] == ZAM_Z_ARRIVING) || (zst_r[g] == ZAM_Z_RELEASE);
      assign run_req[g] = zone_mode ? zrun[g] : central_run[g];
    end
  endgenerate

  zam_channel #(.VW(VW)) u_ch0 (
    .clk            (clk),
    .rst_n          (rst_n),
    .ms_tick        (ms_tick_r),
    .commut_err     (commut_err[0]),
    .manual_ack     (manual_ack[0]),
    .max_attempts   (max_attempts),
    .ack_delay_ms   (ack_delay_ms),
    .run_req        (run_req[0]),
    .vel_set        (vel_set0),
    .vel_meas       (vel_meas0),
    .kp             (kp),
    .ti             (ti),
    .kff            (kff),
    .enabled_r      (en_w[0]),
    .latched_r      (lat_w[0]),
    .attempts_r     (attempts0_r),
    .since_ack_ms_r (since_ack0_r),
    .drive_r        (drive0_r)
  );

  zam_channel #(.VW(VW)) u_ch1 (
    .clk            (clk),
    .rst_n          (rst_n),
    .ms_tick        (ms_tick_r),
    .commut_err     (commut_err[1]),
    .manual_ack     (manual_ack[1]),
    .max_attempts   (max_attempts),
    .ack_delay_ms   (ack_delay_ms),
    .run_req        (run_req[1]),
    .vel_set        (vel_set1),
    .vel_meas       (vel_meas1),
    .kp             (kp),
    .ti             (ti),
    .kff            (kff),
    .enabled_r      (en_w[1]),
    .latched_r      (lat_w[1]),
    .attempts_r     (attempts1_r),
    .since_ack_ms_r (since_ack1_r),
    .drive_r        (drive1_r)
  );

  assign ch_enabled_r = en_w;
  assign ch_latched_r = lat_w;

  // Outer handshake goes to whichever transport is selected; the other stays low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_free_pin_r   <= 1'b0;
      dn_coming_pin_r <= 1'b0;
      up_free_bus_r   <= 1'b0;
      dn_coming_bus_r <= 1'b0;
      zone_full_r     <= 2'b00;
    end else begin
      up_free_pin_r   <= !link_via_bus && zfree_r[0];
      dn_coming_pin_r <= !link_via_bus && zcoming_r[1];
      up_free_bus_r   <= link_via_bus && zfree_r[0];
      dn_coming_bus_r <= link_via_bus && zcoming_r[1];
      zone_full_r     <= present;
    end
  end
endmodule // zam_top

// File: zam_top_checker.sv
// Assertion checker bound to the zone accumulation motor controller top level.
`timescale 1ns/1ps
module zam_top_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [1:0]  commut_err,
  input wire logic [1:0]  manual_ack,
  input wire logic [7:0]  max_attempts,
  input wire logic        link_via_bus,
  input wire logic        up_free_pin_r,
  input wire logic        dn_coming_pin_r,
  input wire logic        up_free_bus_r,
  input wire logic        dn_coming_bus_r,
  input wire logic [1:0]  ch_enabled_r,
  input wire logic [1:0]  ch_latched_r,
  input wire logic [7:0]  attempts0_r,
  input wire logic [15:0] since_ack0_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_err_off0: assert property (ch_enabled_r[0] && commut_err[0] |=> !ch_enabled_r[0])
    else $error("channel 0 stayed enabled after an error");
  a_err_off1: assert property (ch_enabled_r[1] && commut_err[1] |=> !ch_enabled_r[1])
    else $error("channel 1 stayed enabled after an error");
  a_zero_limit_latch: assert property (max_attempts == 8'h00 && ch_enabled_r[0]
    && commut_err[0] |-> ##[1:300] ch_latched_r[0]) else $error("no latch with limit zero");
  a_latch_off: assert property (ch_latched_r[0] |-> !ch_enabled_r[0])
    else $error("latched channel is enabled");
  a_latch_holds: assert property (!manual_ack[0] [*3] ##0 ch_latched_r[0]
    |=> ch_latched_r[0]) else $error("latch cleared without acknowledge");
  a_attempt_step: assert property ($changed(attempts0_r) && attempts0_r != 8'h00
    |-> attempts0_r == $past(attempts0_r) + 8'h01) else $error("attempt count jumped");
  a_attempt_limit: assert property (attempts0_r <= max_attempts)
    else $error("attempt count above limit");
  a_ack_enables: assert property ($changed(attempts0_r) && attempts0_r != 8'h00
    |-> ##[0:2] ch_enabled_r[0]) else $error("auto acknowledge did not re-enable");
  a_since_clear: assert property ($changed(attempts0_r) && attempts0_r != 8'h00
    |-> ##[0:3] since_ack0_r <= 16'h0001) else $error("elapsed time not restarted");
  a_pin_quiet: assert property (link_via_bus && $past(link_via_bus)
    && $past(link_via_bus, 2) |-> !up_free_pin_r && !dn_coming_pin_r)
    else $error("pins active in bus mode");
  a_bus_quiet: assert property (!link_via_bus && !$past(link_via_bus)
    && !$past(link_via_bus, 2) |-> !up_free_bus_r && !dn_coming_bus_r)
    else $error("bus values active in pin mode");
  c_latched: cover property (ch_latched_r[0]);
  c_two_acks: cover property ($changed(attempts0_r) && attempts0_r == 8'h02);
  c_bus_coming: cover property (dn_coming_bus_r);
endmodule // zam_top_checker

bind zam_top zam_top_checker u_chk (.clk, .reset_n, .commut_err, .manual_ack, .max_attempts,
  .link_via_bus, .up_free_pin_r, .dn_coming_pin_r, .up_free_bus_r, .dn_coming_bus_r,
  .ch_enabled_r, .ch_latched_r, .attempts0_r, .since_ack0_r);

// File: zam_neighbors.sv
// Model of the adjacent upstream and downstream zone controllers.
`timescale 1ns/1ps
module zam_neighbors (
  input  wire logic clk,
  input  wire logic link_via_bus,
  input  wire logic up_send,
  input  wire logic dn_accept,
  input  wire logic up_free_pin_r,
  input  wire logic up_free_bus_r,
  output wire logic up_coming_pin,
  output wire logic up_coming_bus,
  output wire logic dn_free_pin,
  output wire logic dn_free_bus
);
  logic coming_r = 1'h0;
  // Upstream announces a package only after this zone reports free.
  always @(posedge clk) begin
    coming_r <= up_send && (coming_r || (link_via_bus ? up_free_bus_r : up_free_pin_r));
  end
  // The unused transport carries the inverse, so a wrong selection shows up.
  assign up_coming_pin = coming_r ^ link_via_bus;
  assign up_coming_bus = coming_r ^ !link_via_bus;
  assign dn_free_pin   = dn_accept ^ link_via_bus;
  assign dn_free_bus   = dn_accept ^ !link_via_bus;
endmodule // zam_neighbors

// File: zam_top_test.sv
// Self-checking testbench for the zone accumulation motor controller.
`timescale 1ns/1ps
module zam_top_test;
  logic        clk = 1'h0, reset_n = 1'h0, zone_mode = 1'h0, train_release = 1'h0;
  logic        link_via_bus = 1'h0, up_send = 1'h0, dn_accept = 1'h0;
  logic        up_coming_pin, up_coming_bus, dn_free_pin, dn_free_bus;
  logic        up_free_pin_r, dn_coming_pin_r, up_free_bus_r, dn_coming_bus_r;
  logic [1:0]  sensor_pin = 2'h0, sensor_low_active = 2'h0, commut_err = 2'h0, lo;
  logic [1:0]  manual_ack = 2'h0, central_run = 2'h0, ch_enabled_r, ch_latched_r, zone_full_r;
  logic [7:0]  max_attempts = 8'h00, kp = 8'h00, ti = 8'h00, kff = 8'h00, attempts0_r, attempts1_r;
  logic [15:0] ack_delay_ms = 16'h0002, since_ack0_r, since_ack1_r;
  logic signed [15:0] vel_set0 = 16'h0000, vel_set1 = 16'h0000, vel_meas0 = 16'h0000;
  logic signed [15:0] vel_meas1 = 16'h0000, drive0_r, drive1_r;
  int          n_errors = 0, checked = 0, cyc, i, m, d10;

  initial forever #2.5 clk = ~clk;

  zam_top #(.VW(16), .TICK_CYCLES(10)) dut (.clk, .reset_n, .sensor_pin, .sensor_low_active,
    .commut_err, .manual_ack, .max_attempts, .ack_delay_ms, .zone_mode, .central_run,
    .train_release, .link_via_bus, .up_coming_pin, .dn_free_pin, .up_coming_bus, .dn_free_bus,
    .vel_set0, .vel_set1, .vel_meas0, .vel_meas1, .kp, .ti, .kff, .up_free_pin_r,
    .dn_coming_pin_r, .up_free_bus_r, .dn_coming_bus_r, .ch_enabled_r, .ch_latched_r,
    .attempts0_r, .attempts1_r, .since_ack0_r, .since_ack1_r, .drive0_r, .drive1_r, .zone_full_r);
  zam_neighbors u_nb (.clk, .link_via_bus, .up_send, .dn_accept, .up_free_pin_r, .up_free_bus_r,
    .up_coming_pin, .up_coming_bus, .dn_free_pin, .dn_free_bus);

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic cond(input int k);
    case (k)
      0: return ch_enabled_r[0];
      1: return !ch_enabled_r[0];
      2: return ch_latched_r[0];
      3: return link_via_bus ? up_free_bus_r : up_free_pin_r;
      default: return link_via_bus ? dn_coming_bus_r : dn_coming_pin_r;
    endcase
  endfunction
  // Waits are bounded so a stuck handshake ends the run instead of hanging it.
  task automatic wait_on(input int k, input int lim);
    cyc = 0;
    while (cond(k) !== 1'h1) begin
      tk(1);
      cyc++;
      if (cyc > lim) begin
        n_errors++;
        $display("Error wait %0d expected 1 seen 0", k);
        results();
      end
    end
  endtask
  task automatic pulse(input logic ack, input logic [1:0] v);
    @(posedge clk);
    if (ack) manual_ack <= v;
    else commut_err <= v;
    @(posedge clk);
    manual_ack <= 2'h0;
    commut_err <= 2'h0;
    #1;
  endtask
  // Integrator is still empty when checked, so only feed-forward and proportional terms count.
  function automatic logic [15:0] drive_exp(input logic [7:0] p, input logic [7:0] f,
                                            input logic signed [15:0] s,
                                            input logic signed [15:0] v);
    logic signed [31:0] acc;
    acc = $signed({1'h0, f}) * s + $signed({1'h0, p}) * (s - v);
    return acc[23:8];
  endfunction

  initial begin
    void'($urandom(55930));
    tk(4);
    chk("enabled", 16'(ch_enabled_r), 16'h0000);
    @(posedge clk);
    @(posedge clk);
    reset_n <= 1'h1;
    tk(6);
    chk("enabled", 16'(ch_enabled_r), 16'h0003);
    chk("attempts", 16'(attempts0_r), 16'h0000);
    chk("attempts1", 16'(attempts1_r), 16'h0000);
    pulse(1'h0, 2'h3);
    wait_on(2, 400);
    tk(100);
    chk("latched", 16'(ch_latched_r), 16'h0003);
    chk("attempts", 16'(attempts0_r), 16'h0000);
    pulse(1'h1, 2'h3);
    wait_on(0, 20);
    tk(2);
    chk("enabled", 16'(ch_enabled_r), 16'h0003);
    $display("test latch done");
    for (m = 0; m < 2; m++) begin
      @(posedge clk);
      zone_mode <= m[0];
      max_attempts <= 8'h02;
      ack_delay_ms <= 16'h0001 + 16'($urandom_range(3));
      for (i = 0; i < 3; i++) begin
        pulse(1'h0, 2'h3);
        wait_on(1, 5);
        if (i < 2) begin
          wait_on(0, 400);
          d10 = 10 * ack_delay_ms;
          chk("delay", 16'(cyc + 10 >= d10 && cyc <= d10 + 15), 16'h0001);
          chk("attempts", 16'(attempts0_r), 16'(i + 1));
          chk("attempts1", 16'(attempts1_r), 16'(i + 1));
          tk(50);
          chk("since", 16'(since_ack0_r >= 4 && since_ack0_r <= 6), 16'h0001);
          chk("since1", 16'(since_ack1_r >= 4 && since_ack1_r <= 6), 16'h0001);
        end else begin
          wait_on(2, 400);
          chk("attempts", 16'(attempts0_r), 16'h0002);
          chk("latched", 16'(ch_latched_r), 16'h0003);
        end
      end
      pulse(1'h1, 2'h3);
      wait_on(0, 20);
      tk(1);
      chk("attempts", 16'(attempts0_r), 16'h0000);
      chk("attempts1", 16'(attempts1_r), 16'h0000);
      $display("test auto acknowledge done");
    end
    @(posedge clk);
    central_run <= 2'h3;
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      zone_mode <= 1'h0;
      kp <= i < 2 ? 8'h00 : 8'($urandom_range(255, 1));
      kff <= i == 0 ? 8'hFF : 8'($urandom);
      ti <= i < 2 ? 8'($urandom) : 8'hFF;
      vel_set0 <= i == 0 ? 16'h8000 : 16'($urandom);
      vel_set1 <= 16'($urandom);
      vel_meas0 <= 16'($urandom);
      vel_meas1 <= 16'($urandom);
      tk(20);
      chk("drive0", drive0_r, drive_exp(kp, kff, vel_set0, vel_meas0));
      chk("drive1", drive1_r, drive_exp(kp, kff, vel_set1, vel_meas1));
    end
    $display("test feed forward done");
    for (m = 0; m < 2; m++) begin
      lo = 2'($urandom);
      @(posedge clk);
      zone_mode <= 1'h1;
      central_run <= 2'h0;
      train_release <= m[0];
      link_via_bus <= 1'($urandom);
      sensor_low_active <= lo;
      sensor_pin <= lo;
      tk(10);
      sensor_pin <= lo ^ 2'h1;
      tk(20);
      chk("zone0 full", 16'(zone_full_r[0]), 16'h0001);
      chk("up free", 16'(cond(3)), 16'(m[0]));
      sensor_pin <= lo;
      wait_on(3, 20);
      tk(5);
      sensor_pin <= lo ^ 2'h2;
      tk(20);
      chk("zone1 full", 16'(zone_full_r[1]), 16'h0001);
      chk("dn coming", 16'(cond(4)), 16'h0000);
      dn_accept <= 1'h1;
      wait_on(4, 20);
      sensor_pin <= lo;
      dn_accept <= 1'h0;
      up_send <= 1'h1;
      tk(20);
      chk("dn coming", 16'(cond(4)), 16'h0000);
      up_send <= 1'h0;
      tk(20);
      $display("test zone handshake done");
    end
    results();
  end
endmodule // zam_top_test
